// ---- hdl/pmac_pkg.sv ----
package pmac_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_PRIV = 8'h04;
    localparam logic [7:0] OFS_GLIMIT = 8'h08;
    localparam logic [7:0] OFS_LLIMIT = 8'h0c;
    localparam logic [7:0] OFS_SEGDESC = 8'h10;
    localparam logic [7:0] OFS_SEGLOAD = 8'h14;
    localparam logic [7:0] OFS_OPDESC = 8'h18;
    localparam logic [7:0] OFS_OPOFS = 8'h1c;
    localparam logic [7:0] OFS_OPCMD = 8'h20;
    localparam logic [7:0] OFS_STKPTR = 8'h24;
    localparam logic [7:0] OFS_INSTR = 8'h28;
    localparam logic [7:0] OFS_FLAGWR = 8'h2c;
    localparam logic [7:0] OFS_RAISE = 8'h30;
    localparam logic [7:0] OFS_INSTADDR = 8'h34;
    localparam logic [7:0] OFS_RETADDR = 8'h38;
    localparam logic [7:0] OFS_RESULT = 8'h3c;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int IOPRIV_HI = 14;
    localparam int IOPRIV_LO = 13;
    localparam int IF_BIT = 9;
    localparam int ACC_P = 7;
    localparam int ACC_PRIV_HI = 6;
    localparam int ACC_PRIV_LO = 5;
    localparam int ACC_S = 4;
    localparam int ACC_X = 3;
    localparam int ACC_C = 2;
    localparam int ACC_RW = 1;
    localparam int SEL_TI = 2;
    localparam int OPC_WRITE = 0;
    localparam int OPC_WORD = 1;
    localparam int OPC_STACK = 2;

    // ****************************************
    // Vectors, reset values, constants
    // ****************************************
    localparam logic [7:0] VEC_DOUBLE = 8'h08;
    localparam logic [7:0] VEC_COPROC = 8'h09;
    localparam logic [7:0] VEC_TSS = 8'h0a;
    localparam logic [7:0] VEC_NOTPRES = 8'h0b;
    localparam logic [7:0] VEC_STACK = 8'h0c;
    localparam logic [7:0] VEC_GP = 8'h0d;
    localparam logic [15:0] FLAGS_RST = 16'h0002;
    localparam logic [15:0] STK_WRAP_A = 16'h0000;
    localparam logic [15:0] STK_WRAP_B = 16'h0001;
    localparam logic [15:0] STK_WRAP_C = 16'hfffe;
    localparam logic [15:0] STK_WRAP_D = 16'hffff;
    localparam logic [15:0] PUSHALL_BYTES = 16'h0010;
    localparam logic [15:0] POPALL_TOP = 16'hfff0;
    localparam logic [15:0] SEL_IDX_MASK = 16'hfffc;
    localparam logic [2:0] DESC_LAST = 3'h7;

    typedef enum logic [1:0] {SEG_EXTRA, SEG_CODE, SEG_STACK, SEG_DATA} pmac_seg_t;

    typedef enum logic [4:0] {
        OP_NONE, OP_LOAD_IDT, OP_LOAD_LOCAL, OP_LOAD_GLOBAL, OP_LOAD_TR, OP_LOAD_MSW,
        OP_CLEAR_TS, OP_HALT, OP_PORT_IN, OP_PORT_OUT, OP_PORT_STR_IN,
        OP_PORT_STR_OUT, OP_SET_IF, OP_CLEAR_IF, OP_LOCK, OP_PUSH_ALL,
        OP_POP_ALL, OP_COPROC_OVERRUN
    } pmac_op_t;

endpackage : pmac_pkg

// ---- hdl/pmac_checker.sv ----
`timescale 1ns/1ps

module pmac_checker (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // APB answer
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr
);

    // ****************************************
    // State
    // ****************************************
    logic [15:0] flags;
    logic [1:0] current_privilege_level;
    logic [15:0] global_limit;
    logic [15:0] local_limit;
    logic [7:0] seg_access;
    logic [7:0] op_access;
    logic [15:0] op_limit;
    logic [15:0] op_base;
    logic [15:0] op_disp;
    logic [15:0] stack_pointer;
    logic [15:0] inst_addr;
    logic [15:0] ret_addr;
    logic res_fault;
    logic res_errpush;
    logic res_restart;
    logic res_retok;
    logic [7:0] res_vector;
    logic [15:0] res_errcode;

    logic wr_en;
    logic rd_setup;
    logic [1:0] io_privilege_level;
    logic cmd;
    logic next_fault;
    logic [7:0] next_vector;
    logic [15:0] next_errcode;
    logic next_unrestartable;
    logic [15:0] next_flags;

    assign wr_en = psel & penable & pready & pwrite;
    assign rd_setup = psel & ~penable;
    assign io_privilege_level = flags[pmac_pkg::IOPRIV_HI:pmac_pkg::IOPRIV_LO];

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic mapped(input logic [7:0] a);
        unique case (a)
            pmac_pkg::OFS_FLAGS, pmac_pkg::OFS_PRIV, pmac_pkg::OFS_GLIMIT,
            pmac_pkg::OFS_LLIMIT, pmac_pkg::OFS_SEGDESC, pmac_pkg::OFS_SEGLOAD,
            pmac_pkg::OFS_OPDESC, pmac_pkg::OFS_OPOFS, pmac_pkg::OFS_OPCMD,
            pmac_pkg::OFS_STKPTR, pmac_pkg::OFS_INSTR, pmac_pkg::OFS_FLAGWR,
            pmac_pkg::OFS_RAISE, pmac_pkg::OFS_INSTADDR, pmac_pkg::OFS_RETADDR,
            pmac_pkg::OFS_RESULT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    // Bits: error code pushed, restartable, return at failing instruction
    function automatic logic [2:0] vec_props(input logic [7:0] v);
        unique case (v)
            pmac_pkg::VEC_DOUBLE: vec_props = 3'b101;
            pmac_pkg::VEC_COPROC: vec_props = 3'b000;
            pmac_pkg::VEC_TSS, pmac_pkg::VEC_NOTPRES,
            pmac_pkg::VEC_STACK: vec_props = 3'b111;
            pmac_pkg::VEC_GP: vec_props = 3'b101;
            default: vec_props = 3'b001;
        endcase
    endfunction : vec_props

    function automatic logic [1:0] max2(input logic [1:0] a, input logic [1:0] b);
        max2 = (a > b) ? a : b;
    endfunction : max2

    // ****************************************
    // Protection checks
    // ****************************************
    always_comb
    begin
        logic [15:0] sel;
        logic [1:0] req_priv;
        logic [1:0] desc_priv;
        logic [15:0] tbl_limit;
        logic type_bad;
        logic priv_bad;
        logic [15:0] first;
        logic [15:0] last;
        logic op_wr;
        pmac_pkg::pmac_seg_t tgt;
        pmac_pkg::pmac_op_t op;
        sel = pwdata[15:0];
        req_priv = sel[1:0];
        desc_priv = seg_access[pmac_pkg::ACC_PRIV_HI:pmac_pkg::ACC_PRIV_LO];
        tbl_limit = sel[pmac_pkg::SEL_TI] ? local_limit : global_limit;
        type_bad = 1'b0;
        priv_bad = 1'b0;
        first = 16'h0000;
        last = 16'h0000;
        op_wr = 1'b0;
        tgt = pmac_pkg::pmac_seg_t'(pwdata[17:16]);
        op = pmac_pkg::pmac_op_t'(pwdata[4:0]);
        cmd = 1'b0;
        next_fault = 1'b0;
        next_vector = 8'h00;
        next_errcode = 16'h0000;
        next_unrestartable = 1'b0;
        if (wr_en)
        begin
            unique case (paddr)
                pmac_pkg::OFS_SEGLOAD:
                begin
                    cmd = 1'b1;
                    unique case (tgt)
                        pmac_pkg::SEG_CODE:
                            type_bad = seg_access[pmac_pkg::ACC_S] &
                                ~seg_access[pmac_pkg::ACC_X];
                        pmac_pkg::SEG_STACK:
                        begin
                            type_bad = ~seg_access[pmac_pkg::ACC_S] |
                                seg_access[pmac_pkg::ACC_X] |
                                ~seg_access[pmac_pkg::ACC_RW];
                            priv_bad = (desc_priv != current_privilege_level) |
                                (req_priv != current_privilege_level);
                        end
                        default:
                        begin
                            type_bad = ~seg_access[pmac_pkg::ACC_S] |
                                (seg_access[pmac_pkg::ACC_X] &
                                ~seg_access[pmac_pkg::ACC_RW]);
                            priv_bad = ~(seg_access[pmac_pkg::ACC_X] &
                                seg_access[pmac_pkg::ACC_C]) &
                                (desc_priv < max2(current_privilege_level, req_priv));
                        end
                    endcase
                    next_errcode = sel & pmac_pkg::SEL_IDX_MASK;
                    if ({sel[15:3], pmac_pkg::DESC_LAST} > tbl_limit)
                    begin
                        next_fault = 1'b1;
                        next_vector = pmac_pkg::VEC_GP;
                    end
                    else if (type_bad | priv_bad)
                    begin
                        next_fault = 1'b1;
                        next_vector = pmac_pkg::VEC_GP;
                    end
                    else if (~seg_access[pmac_pkg::ACC_P])
                    begin
                        next_fault = 1'b1;
                        next_vector = (tgt == pmac_pkg::SEG_STACK) ?
                            pmac_pkg::VEC_STACK : pmac_pkg::VEC_NOTPRES;
                    end
                end
                pmac_pkg::OFS_OPCMD:
                begin
                    cmd = 1'b1;
                    op_wr = pwdata[pmac_pkg::OPC_WRITE];
                    first = 16'(op_base + op_disp);
                    last = 16'(first + {15'h0000, pwdata[pmac_pkg::OPC_WORD]});
                    if (op_wr ? (op_access[pmac_pkg::ACC_X] | ~op_access[pmac_pkg::ACC_RW])
                              : (op_access[pmac_pkg::ACC_X] & ~op_access[pmac_pkg::ACC_RW]))
                    begin
                        next_fault = 1'b1;
                        next_vector = pmac_pkg::VEC_GP;
                    end
                    else if (last > op_limit || last < first)
                    begin
                        next_fault = 1'b1;
                        next_vector = pwdata[pmac_pkg::OPC_STACK] ?
                            pmac_pkg::VEC_STACK : pmac_pkg::VEC_GP;
                    end
                    else if (pwdata[pmac_pkg::OPC_STACK] & ~op_access[pmac_pkg::ACC_P])
                    begin
                        next_fault = 1'b1;
                        next_vector = pmac_pkg::VEC_STACK;
                    end
                end
                pmac_pkg::OFS_INSTR:
                begin
                    cmd = 1'b1;
                    unique case (op)
                        pmac_pkg::OP_LOAD_IDT, pmac_pkg::OP_LOAD_LOCAL, pmac_pkg::OP_LOAD_GLOBAL,
                        pmac_pkg::OP_LOAD_TR, pmac_pkg::OP_LOAD_MSW, pmac_pkg::OP_CLEAR_TS,
                        pmac_pkg::OP_HALT:
                            next_fault = (current_privilege_level != 2'b00);
                        pmac_pkg::OP_PORT_IN, pmac_pkg::OP_PORT_OUT, pmac_pkg::OP_PORT_STR_IN,
                        pmac_pkg::OP_PORT_STR_OUT, pmac_pkg::OP_SET_IF, pmac_pkg::OP_CLEAR_IF,
                        pmac_pkg::OP_LOCK:
                            next_fault = (current_privilege_level > io_privilege_level);
                        pmac_pkg::OP_PUSH_ALL:
                            next_fault = (stack_pointer < pmac_pkg::PUSHALL_BYTES);
                        pmac_pkg::OP_POP_ALL:
                            next_fault = (stack_pointer > pmac_pkg::POPALL_TOP);
                        pmac_pkg::OP_COPROC_OVERRUN:
                            next_fault = 1'b1;
                        default: next_fault = 1'b0;
                    endcase
                    if (op == pmac_pkg::OP_PUSH_ALL || op == pmac_pkg::OP_POP_ALL)
                    begin
                        next_vector = pmac_pkg::VEC_STACK;
                        next_unrestartable = (stack_pointer == pmac_pkg::STK_WRAP_A) |
                            (stack_pointer == pmac_pkg::STK_WRAP_B) |
                            (stack_pointer == pmac_pkg::STK_WRAP_C) |
                            (stack_pointer == pmac_pkg::STK_WRAP_D);
                    end
                    else if (op == pmac_pkg::OP_COPROC_OVERRUN)
                        next_vector = pmac_pkg::VEC_COPROC;
                    else
                        next_vector = pmac_pkg::VEC_GP;
                end
                pmac_pkg::OFS_RAISE:
                begin
                    cmd = 1'b1;
                    next_fault = 1'b1;
                    next_vector = pwdata[7:0];
                    next_errcode = pwdata[31:16];
                end
                default: cmd = 1'b0;
            endcase
        end
    end

    // ****************************************
    // Flag word update
    // ****************************************
    always_comb
    begin
        next_flags = pwdata[15:0];
        if (current_privilege_level > io_privilege_level)
            next_flags[pmac_pkg::IF_BIT] = flags[pmac_pkg::IF_BIT];
        if (current_privilege_level != 2'b00)
            next_flags[pmac_pkg::IOPRIV_HI:pmac_pkg::IOPRIV_LO] = io_privilege_level;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags <= pmac_pkg::FLAGS_RST;
        else if (wr_en && paddr == pmac_pkg::OFS_FLAGS)
            flags <= pwdata[15:0];
        else if (wr_en && paddr == pmac_pkg::OFS_FLAGWR)
            flags <= next_flags;
        else if (wr_en && paddr == pmac_pkg::OFS_INSTR && !next_fault)
        begin
            if (pwdata[4:0] == pmac_pkg::OP_SET_IF)
                flags[pmac_pkg::IF_BIT] <= 1'b1;
            else if (pwdata[4:0] == pmac_pkg::OP_CLEAR_IF)
                flags[pmac_pkg::IF_BIT] <= 1'b0;
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            current_privilege_level <= 2'b00;
            global_limit <= 16'h0000;
            local_limit <= 16'h0000;
            seg_access <= 8'h00;
            op_access <= 8'h00;
            op_limit <= 16'h0000;
            op_base <= 16'h0000;
            op_disp <= 16'h0000;
            stack_pointer <= 16'h0000;
            inst_addr <= 16'h0000;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                pmac_pkg::OFS_PRIV: current_privilege_level <= pwdata[1:0];
                pmac_pkg::OFS_GLIMIT: global_limit <= pwdata[15:0];
                pmac_pkg::OFS_LLIMIT: local_limit <= pwdata[15:0];
                pmac_pkg::OFS_SEGDESC: seg_access <= pwdata[7:0];
                pmac_pkg::OFS_OPDESC:
                begin
                    op_access <= pwdata[7:0];
                    op_limit <= pwdata[31:16];
                end
                pmac_pkg::OFS_OPOFS:
                begin
                    op_base <= pwdata[15:0];
                    op_disp <= pwdata[31:16];
                end
                pmac_pkg::OFS_STKPTR: stack_pointer <= pwdata[15:0];
                pmac_pkg::OFS_INSTADDR: inst_addr <= pwdata[15:0];
                default: inst_addr <= inst_addr;
            endcase
        end
    end

    // ****************************************
    // Exception result
    // ****************************************
    logic [2:0] next_props;
    assign next_props = vec_props(next_vector);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            res_fault <= 1'b0;
            res_errpush <= 1'b0;
            res_restart <= 1'b0;
            res_retok <= 1'b0;
            res_vector <= 8'h00;
            res_errcode <= 16'h0000;
            ret_addr <= 16'h0000;
        end
        else if (cmd)
        begin
            res_fault <= next_fault;
            res_vector <= next_fault ? next_vector : 8'h00;
            res_errpush <= next_fault & next_props[2];
            res_restart <= next_fault & next_props[1] & ~next_unrestartable;
            res_retok <= next_fault & next_props[0];
            res_errcode <= (next_fault & next_props[2]) ? next_errcode : 16'h0000;
            if (next_fault)
                ret_addr <= inst_addr;
        end
    end

    // ****************************************
    // APB answer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= rd_setup;
            pslverr <= rd_setup & ~mapped(paddr);
            prdata <= 32'h0000_0000;
            if (rd_setup && !pwrite)
            begin
                unique case (paddr)
                    pmac_pkg::OFS_FLAGS: prdata <= {16'h0000, flags};
                    pmac_pkg::OFS_PRIV: prdata <= {30'h0000_0000, current_privilege_level};
                    pmac_pkg::OFS_GLIMIT: prdata <= {16'h0000, global_limit};
                    pmac_pkg::OFS_LLIMIT: prdata <= {16'h0000, local_limit};
                    pmac_pkg::OFS_SEGDESC: prdata <= {24'h00_0000, seg_access};
                    pmac_pkg::OFS_OPDESC: prdata <= {op_limit, 8'h00, op_access};
                    pmac_pkg::OFS_OPOFS: prdata <= {op_disp, op_base};
                    pmac_pkg::OFS_STKPTR: prdata <= {16'h0000, stack_pointer};
                    pmac_pkg::OFS_INSTADDR: prdata <= {16'h0000, inst_addr};
                    pmac_pkg::OFS_RETADDR: prdata <= {16'h0000, ret_addr};
                    pmac_pkg::OFS_RESULT: prdata <= {res_errcode, res_vector, 4'h0,
                        res_retok, res_restart, res_errpush, res_fault};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : pmac_checker

// ---- verif/pmac_checker_props.sv ----
`timescale 1ns/1ps

// ****************************************
// Port-level properties
// ****************************************
module pmac_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // Answer
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire acc = psel && penable && pready;
    wire rd_res = acc && !pwrite && paddr == pmac_pkg::OFS_RESULT;
    wire wr_fw = acc && pwrite && paddr == pmac_pkg::OFS_FLAGWR;
    wire [7:0] vec = prdata[15:8];

    property p_answer;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_answer: assert property (p_answer) else $error("ready not one cycle");

    property p_quiet;
        !(psel && penable) |-> !pready && prdata == 32'h0 && !pslverr;
    endproperty
    a_quiet: assert property (p_quiet) else $error("answer outside access");

    property p_vec9;
        rd_res && vec == pmac_pkg::VEC_COPROC |-> prdata[3:0] == 4'h1;
    endproperty
    a_vec9: assert property (p_vec9) else $error("overrun vector flags");

    property p_vec_gp;
        rd_res && (vec == 8'h08 || vec == 8'h0d) |-> prdata[3:0] == 4'hb;
    endproperty
    a_vec_gp: assert property (p_vec_gp) else $error("vector 8/13 flags");

    property p_vec_rs;
        rd_res && (vec == 8'h0a || vec == 8'h0b) |-> prdata[3:0] == 4'hf;
    endproperty
    a_vec_rs: assert property (p_vec_rs) else $error("vector 10/11 flags");

    property p_vec_stack;
        rd_res && vec == 8'h0c |-> prdata[3] && prdata[1] && prdata[0];
    endproperty
    a_vec_stack: assert property (p_vec_stack) else $error("vector 12 flags");

    property p_pass;
        rd_res && !prdata[0] |-> prdata == 32'h0;
    endproperty
    a_pass: assert property (p_pass) else $error("pass leaves fields");

    property p_silent;
        rd_res && $past(wr_fw, 2) |-> !prdata[0];
    endproperty
    a_silent: assert property (p_silent) else $error("flag write faulted");
endmodule : pmac_props

bind pmac_checker pmac_props pmac_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));

// ---- verif/tb_protected_mode_access_checker.sv ----
`timescale 1ns/1ps

module tb_protected_mode_access_checker;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    int n_errors;
    int checked;
    logic [32:0] exp_q[$];
    logic [32:0] x;
    logic [15:0] fl;
    logic [15:0] wv;
    logic [15:0] ef;
    logic [15:0] ia;
    logic [35:0] e;
    logic [35:0] seg_tab [16] = '{36'h3f201000d, 36'h31200080b, 36'h21200080c, 36'h29000080d,
        36'h19200080d, 36'h39800080d, 36'h08000080d, 36'h3d2000b0d, 36'h7f2000900,
        36'h6d200090d, 36'h31201000d, 36'h21000080d, 36'h29a00080d, 36'h3f2000c0d,
        36'hf9e000b00, 36'h19a000800};

    pmac_checker pmac_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            n_errors++;
    endtask : xfer

    task automatic rd(input logic [7:0] a, input logic [32:0] ex);
        exp_q.push_back(ex);
        xfer(1'b0, a, 32'h0);
    endtask : rd

    task automatic chk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] ex);
        xfer(1'b1, a, d);
        rd(pmac_pkg::OFS_RESULT, {1'b0, ex});
    endtask : chk

    function automatic logic [31:0] res(input logic [7:0] v, input logic [15:0] c,
        input logic [3:0] b);
        return (v == 8'h0) ? 32'h0 : {c, v, 4'h0, b};
    endfunction : res

    task automatic opnd(input logic [7:0] ac, input logic [15:0] bs, input logic [15:0] ds,
        input logic [2:0] cm, input logic [7:0] v);
        xfer(1'b1, pmac_pkg::OFS_OPDESC, {16'h0100, 8'h0, ac});
        xfer(1'b1, pmac_pkg::OFS_OPOFS, {ds, bs});
        chk(pmac_pkg::OFS_OPCMD, {29'h0, cm}, res(v, 16'h0, (v == 8'h0d) ? 4'hb : 4'hf));
    endtask : opnd

    task automatic pa(input logic [15:0] sp, input logic [4:0] op, input logic [3:0] b);
        xfer(1'b1, pmac_pkg::OFS_STKPTR, {16'h0, sp});
        chk(pmac_pkg::OFS_INSTR, {27'h0, op}, res((b == 4'h0) ? 8'h0 : 8'h0c, 16'h0, b));
    endtask : pa

    task automatic report_and_stop;
        if (n_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    // ****************************************
    // Clock, monitor, watchdog
    // ****************************************
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            x = (exp_q.size() != 0) ? exp_q.pop_front() : 33'h0;
            checked++;
            if ({pslverr, prdata} !== x)
            begin
                n_errors++;
                $display("MISMATCH at %0t: got %h expected %h", $time, {pslverr, prdata}, x);
            end
        end
    end

    initial
    begin
        #200us;
        n_errors++;
        report_and_stop();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        n_errors = 0;
        checked = 0;
        void'($urandom(92));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(pmac_pkg::OFS_FLAGS, 33'h2);
        rd(8'h40, 33'h100000000);
        for (int c = 0; c < 4; c++)
            for (int i = 0; i < 4; i++)
            begin
                fl = 16'($urandom());
                fl[14:13] = 2'(i);
                wv = 16'($urandom());
                ef = wv;
                if (c > i)
                    ef[9] = fl[9];
                if (c != 0)
                    ef[14:13] = fl[14:13];
                xfer(1'b1, pmac_pkg::OFS_FLAGS, {16'h0, fl});
                xfer(1'b1, pmac_pkg::OFS_PRIV, 32'(c));
                rd(pmac_pkg::OFS_FLAGS, {17'h0, fl});
                chk(pmac_pkg::OFS_FLAGWR, {16'h0, wv}, 32'h0);
                rd(pmac_pkg::OFS_FLAGS, {17'h0, ef});
            end
        ia = 16'($urandom());
        xfer(1'b1, pmac_pkg::OFS_INSTADDR, {16'h0, ia});
        xfer(1'b1, pmac_pkg::OFS_FLAGS, 32'h4000);
        for (int c = 0; c < 4; c++)
            for (int op = 1; op < 15; op++)
            begin
                xfer(1'b1, pmac_pkg::OFS_PRIV, 32'(c));
                chk(pmac_pkg::OFS_INSTR, 32'(op), ((op < 8) ? (c != 0) : (c > 2)) ?
                    32'h0d0b : 32'h0);
            end
        rd(pmac_pkg::OFS_RETADDR, {17'h0, ia});
        xfer(1'b1, pmac_pkg::OFS_PRIV, 32'h0);
        chk(pmac_pkg::OFS_INSTR, 32'd12, 32'h0);
        rd(pmac_pkg::OFS_FLAGS, 33'h4200);
        xfer(1'b1, pmac_pkg::OFS_GLIMIT, 32'h00ff);
        xfer(1'b1, pmac_pkg::OFS_LLIMIT, 32'h0);
        foreach (seg_tab[k])
        begin
            e = seg_tab[k];
            xfer(1'b1, pmac_pkg::OFS_PRIV, {30'h0, e[35:34]});
            xfer(1'b1, pmac_pkg::OFS_SEGDESC, {24'h0, e[31:24]});
            chk(pmac_pkg::OFS_SEGLOAD, {14'h0, e[33:32], e[23:8]}, res(e[7:0],
                e[23:8] & pmac_pkg::SEL_IDX_MASK, (e[7:0] == 8'h0d) ? 4'hb : 4'hf));
        end
        opnd(8'h9a, 16'h0, 16'h0, 3'b001, 8'h0d);
        opnd(8'h98, 16'h0, 16'h0, 3'b000, 8'h0d);
        opnd(8'h90, 16'h0, 16'h0, 3'b001, 8'h0d);
        opnd(8'h92, 16'h00ff, 16'h0001, 3'b010, 8'h0d);
        opnd(8'h92, 16'h00ff, 16'h0001, 3'b110, 8'h0c);
        opnd(8'h92, 16'hfff0, 16'h0020, 3'b011, 8'h0);
        opnd(8'h12, 16'h0010, 16'h0, 3'b100, 8'h0c);
        opnd(8'h92, 16'h0100, 16'h0, 3'b000, 8'h0);
        pa(16'h0000, 5'd15, 4'hb);
        pa(16'h0001, 5'd15, 4'hb);
        pa(16'h000f, 5'd15, 4'hf);
        pa(16'h0010, 5'd15, 4'h0);
        pa(16'hffff, 5'd16, 4'hb);
        pa(16'hfffe, 5'd16, 4'hb);
        pa(16'hfff1, 5'd16, 4'hf);
        pa(16'hfff0, 5'd16, 4'h0);
        chk(pmac_pkg::OFS_INSTR, 32'd17, 32'h0901);
        for (int v = 8; v < 14; v++)
        begin
            wv = 16'($urandom());
            if (v != 9)
                chk(pmac_pkg::OFS_RAISE, {wv, 8'h0, 8'(v)}, res(8'(v), wv,
                    (v == 8 || v == 13) ? 4'hb : 4'hf));
        end
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge pclk);
        report_and_stop();
    end
endmodule : tb_protected_mode_access_checker
